// file: rtl/overhead_channel_access.sv
// overhead channel access: data gating, eoc processor, single bits latch
`timescale 1ns/1ps
module overhead_channel_access
  import oca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire role_t       role,
  input  wire act_state_t  actState,
  input  wire logic        eocTransparent,
  input  wire logic        loop2Closed,
  input  wire logic        frameStrobe,
  input  wire logic        deactivate,
  input  wire mon_word_t   monIn,
  output mon_word_t        monOut,
  input  wire logic        sysValid,
  output logic             sysReady,
  input  wire logic [17:0] sysData,
  output logic             lineTxValid,
  input  wire logic        lineTxReady,
  output logic      [17:0] lineTxData,
  input  wire logic        lineRxValid,
  output logic             lineRxReady,
  input  wire logic [17:0] lineRxData,
  output logic             sysRxValid,
  input  wire logic        sysRxReady,
  output logic      [17:0] sysRxData,
  input  wire eoc_msg_t    eocRx,
  output eoc_msg_t         eocTx,
  output logic      [11:0] overheadSingleBits,
  output eoc_cmd_t         eocCmd
);

  // ---------------------------------------------------------------
  // state decoding
  // ---------------------------------------------------------------
  function automatic logic dataState(input role_t r, input act_state_t s);
    unique case (r)
      ROLE_LT:    return s inside {ST_PEND_TRANSP, ST_TRANSP, ST_PEND_DEACT,
                                   ST_LINE_ACTIVE, ST_ST_DEACT};
      ROLE_LT_RP: return s inside {ST_PEND_TRANSP, ST_TRANSP, ST_PEND_DEACT};
      ROLE_NT:    return s inside {ST_TRANSP, ST_ERROR_ST, ST_PEND_DEACT_U};
      default:    return 1'b0;
    endcase
  endfunction : dataState

  function automatic logic eocState(input role_t r, input act_state_t s);
    if (r == ROLE_NT) begin
      return s inside {ST_SYNCED, ST_WAIT_ACT, ST_TRANSP, ST_ERROR_ST,
                       ST_PEND_DEACT_U};
    end
    return s inside {ST_EC_CONV, ST_EQ_TRAIN, ST_LINE_ACTIVE, ST_PEND_TRANSP,
                     ST_TRANSP, ST_PEND_DEACT, ST_ST_DEACT};
  endfunction : eocState

  logic isNt;
  logic dataOn;
  logic txDataOn;
  logic eocOn;
  assign isNt     = role == ROLE_NT;
  assign dataOn   = dataState(role, actState);
  assign txDataOn = dataOn && !(isNt && loop2Closed);
  assign eocOn    = eocState(role, actState);

  // ---------------------------------------------------------------
  // data fifos
  // ---------------------------------------------------------------
  logic        txFifoValid;
  logic [17:0] txFifoData;
  logic        rxFifoValid;
  logic [17:0] rxFifoData;
  logic        txFifoReady;
  logic        rxFifoInReady;
  logic        rxFifoOutReady;

  assign sysReady    = txFifoReady && txDataOn;
  assign lineRxReady = rxFifoInReady && dataOn;

  oca_fifo #(.WIDTH(18), .DEPTH(32)) txFifo (
    .mclk    (mclk),
    .rst     (rst),
    .inValid (sysValid && txDataOn),
    .inReady (txFifoReady),
    .inData  (sysData),
    .outValid(txFifoValid),
    .outReady(!lineTxValid || lineTxReady),
    .outData (txFifoData),
    .flush   (!txDataOn)
  );

  oca_fifo #(.WIDTH(18), .DEPTH(32)) rxFifo (
    .mclk    (mclk),
    .rst     (rst),
    .inValid (lineRxValid && dataOn),
    .inReady (rxFifoInReady),
    .inData  (lineRxData),
    .outValid(rxFifoValid),
    .outReady(rxFifoOutReady),
    .outData (rxFifoData),
    .flush   (!dataOn)
  );

  assign rxFifoOutReady = !sysRxValid || sysRxReady;

  always_ff @(posedge mclk) begin
    if (rst) begin
      lineTxValid <= 1'b0;
      lineTxData  <= '0;
    end else if (!lineTxValid || lineTxReady) begin
      lineTxValid <= txFifoValid && txDataOn;
      lineTxData  <= txFifoData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sysRxValid <= 1'b0;
      sysRxData  <= '0;
    end else if (rxFifoOutReady) begin
      sysRxValid <= rxFifoValid && dataOn;
      sysRxData  <= rxFifoData;
    end
  end

  // ---------------------------------------------------------------
  // message intake
  // ---------------------------------------------------------------
  logic     isEocCmd;
  logic     isSbMsg;
  eoc_msg_t cmdMsg;
  assign isEocCmd = monIn.valid && monIn.word[PREFIX_MSB:PREFIX_LSB] == EOC_PREFIX;
  assign isSbMsg  = monIn.valid && monIn.word[PREFIX_MSB:PREFIX_LSB] == SB_PREFIX;
  assign cmdMsg   = eoc_msg_t'(monIn.word[EOC_WIDTH-1:0]);

  // single bits in order m41 m51 m61 m42 m52 m62 m43 m44 m45 m46 m47 m48
  always_ff @(posedge mclk) begin
    if (rst) begin
      overheadSingleBits <= SB_DEFAULT;
    end else if (isSbMsg) begin
      overheadSingleBits <= monIn.word[SB_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // triple-last-look on received eoc slots
  // ---------------------------------------------------------------
  eoc_msg_t lastRx_q;
  logic [1:0] sameCnt_q;
  logic       verified;
  logic       newVerify;
  assign verified  = frameStrobe && eocRx == lastRx_q && sameCnt_q == 2'(TLL_COUNT - 1);
  assign newVerify = verified;

  always_ff @(posedge mclk) begin
    if (rst) begin
      lastRx_q  <= eoc_msg_t'(EOC_IDLE);
      sameCnt_q <= '0;
    end else if (isEocCmd && !isNt && !eocTransparent) begin
      sameCnt_q <= '0;
    end else if (frameStrobe) begin
      lastRx_q <= eocRx;
      // count of equal looks, first look of a new message is one
      if (eocRx != lastRx_q) begin
        sameCnt_q <= 2'h1;
      end else if (sameCnt_q != 2'(TLL_COUNT)) begin
        sameCnt_q <= sameCnt_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // eoc transmit, report and execute
  // ---------------------------------------------------------------
  eoc_msg_t   txMsg_q;
  eoc_msg_t   accepted_q;
  eoc_msg_t   ackedRx_q;
  logic       cmdPending_q;
  logic [5:0] reportCnt_q;
  logic       addrOk;
  logic       addrOkV;
  logic       tick6ms;
  eoc_msg_t   ackMsg;

  assign addrOk  = eocRx.addr == ADDR_NT || eocRx.addr == ADDR_BCAST;
  assign addrOkV = addrOk && eocRx.isMsg;
  assign tick6ms = frameStrobe && reportCnt_q == REPORT_LAST;

  always_comb begin
    ackMsg = eocRx;
    ackMsg.addr = ADDR_NT;
    if (!eocRx.isMsg) begin
      ackMsg.code  = CODE_UTC;
      ackMsg.isMsg = 1'b1;
    end else if (!addrOk) begin
      ackMsg.code  = CODE_HOLD;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !eocOn) begin
      reportCnt_q <= '0;
    end else if (frameStrobe) begin
      reportCnt_q <= tick6ms ? '0 : reportCnt_q + 1'b1;
    end
  end

  // transmitted eoc word, repeated every slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      txMsg_q   <= eoc_msg_t'(EOC_IDLE);
      ackedRx_q <= eoc_msg_t'(EOC_IDLE);
    end else if (isEocCmd && !(isNt && !eocTransparent)) begin
      txMsg_q <= cmdMsg;
    end else if (isNt && !eocTransparent && frameStrobe && eocRx != ackedRx_q
                 && eocRx != lastRx_q) begin
      txMsg_q   <= ackMsg;
      ackedRx_q <= eocRx;
    end
  end

  always_ff @(posedge mclk) begin
    eocTx <= eocOn ? txMsg_q : eoc_msg_t'(EOC_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdPending_q <= 1'b0;
    end else if (isEocCmd && !isNt && !eocTransparent) begin
      cmdPending_q <= 1'b1;
    end else if (verified) begin
      cmdPending_q <= 1'b0;
    end
  end

  // upstream reports
  always_ff @(posedge mclk) begin
    if (rst) begin
      monOut     <= '0;
      accepted_q <= eoc_msg_t'(EOC_IDLE);
    end else begin
      monOut.valid <= 1'b0;
      if (eocOn && eocTransparent && tick6ms) begin
        monOut <= '{valid: 1'b1, word: {EOC_PREFIX, lastRx_q}};
      end else if (eocOn && !eocTransparent && newVerify
                   && (eocRx != accepted_q || (!isNt && cmdPending_q))) begin
        monOut     <= '{valid: 1'b1, word: {EOC_PREFIX, eocRx}};
        accepted_q <= eocRx;
      end
    end
  end

  // latched command execution in nt auto
  always_ff @(posedge mclk) begin
    if (rst || deactivate || !isNt || eocTransparent) begin
      eocCmd <= '0;
    end else if (newVerify && addrOkV) begin
      unique case (eocRx.code)
        CODE_FULL_LOOP:  eocCmd.closeFullLoop     <= 1'b1;
        CODE_LOOP_B1:    eocCmd.closeLoopB1       <= 1'b1;
        CODE_LOOP_B2:    eocCmd.closeLoopB2       <= 1'b1;
        CODE_REQ_CRC:    eocCmd.requestCorruptCrc <= 1'b1;
        CODE_NOTIFY_CRC: eocCmd.notifyCorruptCrc  <= 1'b1;
        CODE_RTN:        eocCmd                   <= '0;
        default: begin
        end
      endcase
    end
  end

  // crc and sync word have no input here; the line core makes them

endmodule : overhead_channel_access

// file: rtl/oca_pkg.sv
// package with constants and carrier types for the overhead channel access block
package oca_pkg;

  // ---------------------------------------------------------------
  // message prefixes and field layout
  // ---------------------------------------------------------------
  localparam logic [3:0] EOC_PREFIX     = 4'h0;
  localparam logic [3:0] SB_PREFIX      = 4'h2;
  localparam int         PREFIX_MSB     = 15;
  localparam int         PREFIX_LSB     = 12;
  localparam int         EOC_WIDTH      = 12;
  localparam int         SB_WIDTH       = 12;

  // ---------------------------------------------------------------
  // predefined eoc codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_HOLD      = 8'h00;
  localparam logic [7:0] CODE_FULL_LOOP = 8'h50;
  localparam logic [7:0] CODE_LOOP_B1   = 8'h51;
  localparam logic [7:0] CODE_LOOP_B2   = 8'h52;
  localparam logic [7:0] CODE_REQ_CRC   = 8'h53;
  localparam logic [7:0] CODE_NOTIFY_CRC = 8'h54;
  localparam logic [7:0] CODE_UTC       = 8'hAA;
  localparam logic [7:0] CODE_RTN       = 8'hFF;
  localparam logic [2:0] ADDR_NT        = 3'h0;
  localparam logic [2:0] ADDR_BCAST     = 3'h7;
  localparam logic [3:0] NT_ACK_BYTE    = 4'h1;
  localparam logic [11:0] EOC_IDLE      = 12'hFFF;
  localparam logic [11:0] SB_DEFAULT    = 12'hFFF;
  localparam int         TLL_COUNT      = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int FRAME_RATE_HZ      = 8000;
  localparam int TRANSP_REPORT_MS   = 6;
  localparam int TRANSP_REPORT_FRMS = FRAME_RATE_HZ * TRANSP_REPORT_MS / 1000;
  localparam logic [5:0] REPORT_LAST = 6'(TRANSP_REPORT_FRMS - 1);

  // ---------------------------------------------------------------
  // states and modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ROLE_LT, ROLE_LT_RP, ROLE_NT} role_t;

  typedef enum logic [3:0] {
    ST_OTHER, ST_EC_CONV, ST_EQ_TRAIN, ST_LINE_ACTIVE, ST_PEND_TRANSP, ST_TRANSP,
    ST_PEND_DEACT, ST_ST_DEACT, ST_SYNCED, ST_WAIT_ACT, ST_ERROR_ST, ST_PEND_DEACT_U
  } act_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       isMsg;
    logic [7:0] code;
  } eoc_msg_t;

  typedef struct packed {
    logic closeFullLoop;
    logic closeLoopB1;
    logic closeLoopB2;
    logic requestCorruptCrc;
    logic notifyCorruptCrc;
  } eoc_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [15:0] word;
  } mon_word_t;

endpackage : oca_pkg

// file: rtl/oca_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module oca_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule : oca_fifo

// file: verif/oca_monitor.sv
// port checker for the overhead channel access block
`timescale 1ns/1ps
module oca_monitor
  import oca_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire role_t       role,
  input wire act_state_t  actState,
  input wire logic        eocTransparent,
  input wire logic        frameStrobe,
  input wire logic        deactivate,
  input wire mon_word_t   monIn,
  input wire mon_word_t   monOut,
  input wire logic        sysReady,
  input wire logic        lineRxReady,
  input wire eoc_msg_t    eocTx,
  input wire logic [11:0] overheadSingleBits,
  input wire eoc_cmd_t    eocCmd
);
  logic nt, eocOn, dataOn, sbMsg, cmdLt, ntIdle;
  assign nt = role == ROLE_NT;
  assign eocOn = nt ? actState inside {ST_SYNCED, ST_WAIT_ACT, ST_TRANSP, ST_ERROR_ST,
    ST_PEND_DEACT_U} : actState inside {ST_EC_CONV, ST_EQ_TRAIN, ST_LINE_ACTIVE,
    ST_PEND_TRANSP, ST_TRANSP, ST_PEND_DEACT, ST_ST_DEACT};
  assign dataOn = nt ? actState inside {ST_TRANSP, ST_ERROR_ST, ST_PEND_DEACT_U}
    : (actState inside {ST_PEND_TRANSP, ST_TRANSP, ST_PEND_DEACT}
    || (role == ROLE_LT && actState inside {ST_LINE_ACTIVE, ST_ST_DEACT}));
  assign sbMsg = monIn.valid && monIn.word[15:12] == SB_PREFIX;
  assign cmdLt = monIn.valid && monIn.word[15:12] == EOC_PREFIX && !nt;
  assign ntIdle = nt && !eocTransparent && eocOn && !frameStrobe;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_lt_data_gate: assert property (
    (!nt && !dataOn) ##1 (!nt && !dataOn) |-> !sysReady && !lineRxReady)
    else $error("lt data path open in a closed state");
  a_nt_data_gate: assert property (
    (nt && !dataOn) ##1 (nt && !dataOn) |-> !sysReady && !lineRxReady)
    else $error("nt data path open in a closed state");
  a_eoc_forced_ones: assert property (
    !eocOn ##1 !eocOn |-> eocTx == EOC_IDLE) else $error("eoc bits not forced high");
  a_eoc_cmd_repeat: assert property (
    (cmdLt && eocOn) ##1 eocOn ##1 eocOn |-> eocTx == $past(monIn.word[11:0], 2))
    else $error("command not placed on the line");
  a_nt_cmd_ignored: assert property (
    ntIdle [*3] |-> $stable(eocTx)) else $error("eoc output moved without a slot");
  a_sb_latch_word: assert property (
    sbMsg |=> overheadSingleBits == $past(monIn.word[11:0]))
    else $error("single bits not latched");
  a_sb_hold_value: assert property (
    !sbMsg |=> $stable(overheadSingleBits)) else $error("single bits changed");
  a_report_one_cycle: assert property (
    monOut.valid |=> !monOut.valid) else $error("report longer than a cycle");
  a_report_after_slot: assert property (
    monOut.valid |-> $past(frameStrobe)) else $error("report without a slot");
  a_cmd_after_slot: assert property (
    !$stable(eocCmd) |-> $past(frameStrobe) || $past(frameStrobe, 2)
    || $past(deactivate) || $past(deactivate, 2)) else $error("command changed off slot");
  a_deact_clears_cmd: assert property (
    deactivate |-> ##[1:2] eocCmd == '0) else $error("deactivation kept commands");
  c_report: cover property (monOut.valid);
  c_loop_b1: cover property (eocCmd.closeLoopB1);
  c_fifo_full: cover property (dataOn && !sysReady);
endmodule : oca_monitor

bind overhead_channel_access oca_monitor chk (.mclk(mclk), .rst(rst), .role(role),
  .actState(actState), .eocTransparent(eocTransparent), .frameStrobe(frameStrobe),
  .deactivate(deactivate), .monIn(monIn), .monOut(monOut), .sysReady(sysReady),
  .lineRxReady(lineRxReady), .eocTx(eocTx), .overheadSingleBits(overheadSingleBits),
  .eocCmd(eocCmd));

// file: verif/oca_line_model.sv
// remote line transceiver model: takes line tx words, sends a counting rx stream
`timescale 1ns/1ps
module oca_line_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        sendEn,
  input  wire logic        lineTxValid,
  output logic             lineTxReady,
  input  wire logic [17:0] lineTxData,
  output logic             lineRxValid,
  input  wire logic        lineRxReady,
  output logic      [17:0] lineRxData
);
  logic [17:0] gotQ[$];
  logic [17:0] nextVal;
  assign lineTxReady = !stall;
  always @(posedge mclk) begin
    if (rst) begin
      lineRxValid <= 1'b0;
      lineRxData  <= 18'h3FFFF;
      nextVal     <= 18'h00000;
    end else begin
      if (lineTxValid && lineTxReady) gotQ.push_back(lineTxData);
      if (lineRxValid && lineRxReady) begin
        lineRxValid <= 1'b0;
        lineRxData  <= ~lineRxData;
        nextVal     <= nextVal + 18'h1;
      end else if (!lineRxValid && sendEn) begin
        lineRxValid <= 1'b1;
        lineRxData  <= nextVal;
      end
    end
  end
endmodule : oca_line_model

// file: verif/tb_overhead_channel_access.sv
// self-checking bench for the overhead channel access block
`timescale 1ns/1ps
`define CHECK(got, exp, what) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value at %0t: %s", $time, what); end end
module tb_overhead_channel_access
  import oca_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, eocTransparent = 1'b0, loop2Closed = 1'b0;
  logic frameStrobe = 1'b0, deactivate = 1'b0, sysValid = 1'b0, sysRxReady = 1'b1;
  logic stall = 1'b1, sendEn = 1'b0;
  role_t role = ROLE_LT;
  act_state_t actState = ST_OTHER;
  mon_word_t monIn = '0, monOut;
  eoc_msg_t eocRx = 12'hFFF, eocTx, m;
  eoc_cmd_t eocCmd;
  logic [17:0] sysData = '0, lineTxData, lineRxData, sysRxData;
  logic sysReady, lineTxValid, lineTxReady, lineRxValid, lineRxReady, sysRxValid;
  logic [11:0] overheadSingleBits;
  logic [15:0] lastRep;
  logic [17:0] sent[$];
  int error_cnt = 0, checks = 0, cycles = 0, reps = 0, rxNext = 0, n;
  logic [28:0] tab [9] = '{{12'h150, 12'h150, 5'h10}, {12'hF51, 12'h151, 5'h08},
    {12'h152, 12'h152, 5'h04}, {12'hF53, 12'h153, 5'h02}, {12'h154, 12'h154, 5'h01},
    {12'h1FF, 12'h1FF, 5'h00}, {12'h050, 12'h1AA, 5'h00}, {12'hB51, 12'h100, 5'h00},
    {12'h150, 12'h150, 5'h10}};

  overhead_channel_access dut (.*);
  oca_line_model line (.*);

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (monOut.valid === 1'b1) begin
      reps++;
      lastRep = monOut.word;
    end
    if (sysRxValid && sysRxReady) begin
      `CHECK(sysRxData, 18'(rxNext), "receive order")
      rxNext++;
    end
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task automatic mon(logic [15:0] w);
    @(posedge mclk) monIn <= '{1'b1, w};
    @(posedge mclk) monIn.valid <= 1'b0;
  endtask : mon
  task automatic slot(eoc_msg_t s, int k);
    repeat (k) begin
      @(posedge mclk) begin eocRx <= s; frameStrobe <= 1'b1; end
      @(posedge mclk) frameStrobe <= 1'b0;
      tick(1);
    end
  endtask : slot

  task automatic t_sbits();
    `CHECK(eocTx, EOC_IDLE, "eoc idle after reset")
    `CHECK(eocCmd, 5'h00, "no command after reset")
    `CHECK(overheadSingleBits, SB_DEFAULT, "single bits default")
    mon(16'h2A5C);
    tick(1);
    `CHECK(overheadSingleBits, 12'hA5C, "single bits latched")
  endtask : t_sbits
  task automatic t_lt_auto();
    @(posedge mclk) actState <= ST_TRANSP;
    mon(16'h0151);
    tick(2);
    `CHECK(eocTx, 12'h151, "command on line")
    n = reps;
    slot(12'h151, 3);
    tick(1);
    `CHECK(reps, n + 1, "return message after three slots")
    slot(12'h151, 3);
    tick(1);
    `CHECK(reps, n + 1, "unchanged message reported")
    slot(12'h3C2, 3);
    tick(1);
    `CHECK(lastRep, 16'h03C2, "foreign message report")
    `CHECK(reps, n + 2, "changed message not reported")
    mon(16'h03C2);
    slot(12'h3C2, 3);
    tick(1);
    `CHECK(reps, n + 3, "equal message after command")
    @(posedge mclk) actState <= ST_OTHER;
    tick(3);
    `CHECK(eocTx, EOC_IDLE, "eoc not forced high")
  endtask : t_lt_auto
  task automatic t_transp(role_t r, int k, eoc_msg_t s);
    @(posedge mclk) begin role <= r; eocTransparent <= 1'b1; actState <= ST_TRANSP; end
    tick(3);
    m = eocTx;
    n = reps;
    slot(s, k);
    tick(1);
    `CHECK(reps, n + k / 48, "periodic report count")
    `CHECK(lastRep, {4'h0, s}, "periodic report content")
    `CHECK(eocCmd, 5'h00, "transparent mode executed")
    if (r == ROLE_NT) `CHECK(eocTx, m, "transparent mode acknowledged")
  endtask : t_transp
  task automatic t_nt_auto();
    @(posedge mclk) begin role <= ROLE_NT; eocTransparent <= 1'b0; end
    tick(3);
    m = eocTx;
    mon(16'h0152);
    tick(2);
    `CHECK(eocTx, m, "nt took a port command")
    foreach (tab[i]) begin
      n = reps;
      slot(tab[i][28:17], 1);
      tick(1);
      `CHECK(eocTx, tab[i][16:5], "acknowledge")
      `CHECK(eocCmd & tab[i][4:0], 5'h00, "executed early")
      slot(tab[i][28:17], 2);
      tick(1);
      if (tab[i][4:0] != 0) `CHECK(eocCmd & tab[i][4:0], tab[i][4:0], "exec")
      else `CHECK(eocCmd, 5'h00, "command kept or wrongly run")
      `CHECK(reps, n + 1, "one report per message")
    end
    @(posedge mclk) deactivate <= 1'b1;
    @(posedge mclk) deactivate <= 1'b0;
    tick(2);
    `CHECK(eocCmd, 5'h00, "deactivation kept commands")
  endtask : t_nt_auto
  task automatic t_data();
    @(posedge mclk) begin eocTransparent <= 1'b0; sysValid <= 1'b1; sendEn <= 1'b1; end
    repeat (50) begin
      @(posedge mclk);
      if (sysReady) sent.push_back(sysData);
      if (sysReady) sysData <= sysData + 18'h1;
    end
    `CHECK(sent.size(), 33, "fifo depth")
    @(posedge mclk) begin sysValid <= 1'b0; stall <= 1'b0; sendEn <= 1'b0; end
    tick(60);
    `CHECK(line.gotQ.size(), sent.size(), "words lost")
    foreach (sent[i]) `CHECK(line.gotQ[i], sent[i], "transmit order")
    `CHECK(rxNext, 26, "receive stream")
    @(posedge mclk) loop2Closed <= 1'b1;
    tick(2);
    `CHECK(sysReady, 1'b0, "loop 2 closed, transmit open")
    `CHECK(lineRxReady, 1'b1, "loop 2 closed, receive shut")
    @(posedge mclk) begin loop2Closed <= 1'b0; actState <= ST_SYNCED; end
    tick(2);
    `CHECK(sysReady, 1'b0, "nt data open")
    @(posedge mclk) begin role <= ROLE_LT_RP; actState <= ST_LINE_ACTIVE; end
    tick(2);
    `CHECK(sysReady, 1'b0, "repeater data open")
    @(posedge mclk) role <= ROLE_LT;
    tick(2);
    `CHECK(sysReady, 1'b1, "lt data closed")
  endtask : t_data

  initial begin
    tick(4);
    @(posedge mclk) rst <= 1'b0;
    tick(1);
    t_sbits();
    t_lt_auto();
    t_transp(ROLE_LT, 96, 12'h8A5);
    t_nt_auto();
    t_transp(ROLE_NT, 48, 12'h153);
    t_data();
    test_done();
  end
endmodule : tb_overhead_channel_access
